//--- src/serial_ctrl_port.sv
`timescale 1ns/100ps
`include "serial_ctrl_params.svh"
// Function
// - register byte bit0 action, bits1-7 address
// - data high byte first, msb first
// - code 11 hands data line to device
// - echo address with invalid flag bit0
// - then return high and low data
// - power, volume, multiplex fields and defaults
// - sound feature fields and defaults
// - status registers 18H and 38H
// - mode low address byte, high data
// - bytes shift lsb first
// - restore resets only serial settings
module serial_ctrl_port #(
	parameter logic [5:0] DEVICE_ADDRESS = `DEVICE_ADDRESS_DEFAULT // arbitrary
) (
	input  wire logic                    clk_sys,
	input  wire logic                    rst_n,
	input  wire logic                    serial_clock_line,
	input  wire logic                    frame_mode_line,
	input  wire logic                    serial_data_line_in,
	output logic                         serial_data_line_out,
	output logic                         serial_data_line_oe,
	input  wire serial_ctrl_pkg::status_t status_in,
	output serial_ctrl_pkg::settings_t   settings
);
	import serial_ctrl_pkg::*;

	// ------------------------------------------------------------
	// link domain: byte shifter on the serial clock
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		S_IDLE  = 4'b0001,
		S_REG   = 4'b0010,
		S_DATA  = 4'b0100,
		S_READ  = 4'b1000
	} link_state_t;

	link_state_t state;
	logic [2:0]  bit_cnt;
	logic [7:0]  shift;
	logic [6:0]  reg_addr;
	logic [6:0]  prep_addr;
	logic [7:0]  hi_byte;
	logic        data_second;
	logic [1:0]  read_idx;
	logic        link_rst_m;
	logic        link_rst;
	logic        wr_toggle;
	logic        prep_toggle;
	write_req_t  wr_hold;
	logic        mode_q;

	wire         link_rst_n = rst_n;
	wire  [7:0]  next_shift = {serial_data_line_in, shift[7:1]};
	wire         byte_done  = bit_cnt == `BITS_PER_BYTE;
	wire         mode_edge  = frame_mode_line != mode_q;
	// transfer code read as {bit 1, bit 0} of the address byte
	wire  [1:0]  type_code  = next_shift[1:0];
	wire         addr_hit   = next_shift[7:2] == DEVICE_ADDRESS;
	wire  [7:0]  rx_rev;
	wire  [6:0]  rx_addr    = rx_rev[6:0];

	// first bit in time lands in the top bit of data; the register address takes the next seven bits, msb first
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_rev
			assign rx_rev[gi] = next_shift[7 - gi];
		end
	endgenerate

	// link reset is the system reset carried over by a two-stage sync
	always_ff @(posedge serial_clock_line) begin
		link_rst_m <= ~link_rst_n;
		link_rst   <= link_rst_m;
	end

	always_ff @(posedge serial_clock_line) begin
		if (link_rst) begin
			state       <= S_IDLE;
			bit_cnt     <= 3'h0;
			shift       <= 8'h00;
			reg_addr    <= 7'h00;
			prep_addr   <= 7'h00;
			hi_byte     <= 8'h00;
			data_second <= 1'b0;
			read_idx    <= 2'h0;
			wr_toggle   <= 1'b0;
			prep_toggle <= 1'b0;
			wr_hold     <= '0;
			mode_q      <= 1'b0;
		end else begin
			mode_q  <= frame_mode_line;
			shift   <= next_shift;
			bit_cnt <= mode_edge ? 3'h1 : bit_cnt + 3'h1;
			if (!frame_mode_line && (byte_done || mode_edge)) begin
				// byte boundary realigns on mode change; full byte decodes
				if (byte_done && !mode_edge) begin
					if (addr_hit && type_code == `TYPE_WRITE_OR_PREPARE)
						state <= S_REG;
					else if (addr_hit && type_code == `TYPE_READ_DATA)
						state <= S_READ;
					else
						state <= S_IDLE;
					read_idx <= 2'h0;
				end
			end else if (frame_mode_line && byte_done && !mode_edge) begin
				case (state)
					S_REG: begin
						if (next_shift[0]) begin
							prep_addr   <= rx_addr;
							prep_toggle <= ~prep_toggle;
						end else begin
							reg_addr    <= rx_addr;
							data_second <= 1'b0;
						end
						state <= next_shift[0] ? S_IDLE : S_DATA;
					end
					S_DATA: begin
						if (!data_second) begin
							hi_byte     <= rx_rev;
							data_second <= 1'b1;
						end else begin
							wr_hold   <= '{1'b1, reg_addr,
								{hi_byte, rx_rev}};
							wr_toggle <= ~wr_toggle;
							state     <= S_IDLE;
						end
					end
					S_READ: begin
						read_idx <= (read_idx == 2'h2) ? 2'h2
							: read_idx + 2'h1;
						if (read_idx == 2'h2)
							state <= S_IDLE;
					end
					default: state <= S_IDLE;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// read-back: data line driven on the falling edge, echo byte lsb first, data bytes msb first
	// ------------------------------------------------------------
	logic [15:0] rd_sync_m;
	logic [15:0] rd_sync;
	logic        valid_m;
	logic        valid_s;
	logic [15:0] rd_data;
	logic        rd_valid;

	// slow settings are stable words; two stages retime them
	always_ff @(posedge serial_clock_line) begin
		rd_sync_m <= rd_data;
		rd_sync   <= rd_sync_m;
		valid_m   <= rd_valid;
		valid_s   <= valid_m;
	end

	logic [7:0] tx_byte;
	always_comb begin
		tx_byte = 8'h00;
		case (read_idx)
			2'h0: tx_byte = {prep_addr[0], prep_addr[1], prep_addr[2],
				prep_addr[3], prep_addr[4], prep_addr[5],
				prep_addr[6], ~valid_s};
			2'h1: tx_byte = rd_sync[15:8];
			default: tx_byte = rd_sync[7:0];
		endcase
	end

	wire read_phase = state == S_READ && frame_mode_line;
	wire [2:0] tx_bit = mode_edge ? 3'h0 : bit_cnt;

	always_ff @(negedge serial_clock_line) begin
		if (link_rst) begin
			serial_data_line_out <= 1'b0;
			serial_data_line_oe  <= 1'b0;
		end else begin
			serial_data_line_oe  <= read_phase;
			serial_data_line_out <= read_idx == 2'h0 ?
				tx_byte[tx_bit] : tx_byte[3'h7 - tx_bit];
		end
	end

	// ------------------------------------------------------------
	// system domain: write crossing and register file
	// ------------------------------------------------------------
	logic [2:0]  tog_sync;
	write_req_t  wr_req;
	logic [15:0] reg_sys;
	logic [15:0] reg_sound;
	logic [15:0] reg_vol;
	logic [15:0] reg_mux;
	logic [2:0]  ptog_sync;
	logic [6:0]  prep_s;

	// the valid bit gates the toggle, so a link reset cannot fake a write
	wire wr_event   = tog_sync[2] != tog_sync[1] && wr_req.wr;
	wire prep_event = ptog_sync[2] != ptog_sync[1];

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			tog_sync  <= 3'h0;
			ptog_sync <= 3'h0;
			prep_s    <= 7'h00;
		end else begin
			tog_sync  <= {tog_sync[1:0], wr_toggle};
			ptog_sync <= {ptog_sync[1:0], prep_toggle};
			if (prep_event)
				prep_s <= prep_addr;
		end
	end
	// hold word is stable long before the toggle arrives
	assign wr_req = wr_hold;

	wire restore = wr_event && wr_req.addr == `REG_RESTORE_DEFAULTS;

	always_ff @(posedge clk_sys) begin
		if (!rst_n || restore) begin
			reg_sys   <= `RST_SYSTEM_PARAMETERS;
			reg_sound <= `RST_SOUND_FEATURES;
			reg_vol   <= `RST_VOLUME_ATTENUATION;
			reg_mux   <= `RST_MULTIPLEX_PARAMETERS;
		end else if (wr_event) begin
			if (wr_req.addr == `REG_SYSTEM_PARAMETERS)
				reg_sys <= wr_req.data & `MASK_SYSTEM_PARAMETERS;
			else if (wr_req.addr == `REG_SOUND_FEATURES)
				reg_sound <= wr_req.data & `MASK_SOUND_FEATURES;
			else if (wr_req.addr == `REG_VOLUME_ATTENUATION)
				reg_vol <= wr_req.data & `MASK_VOLUME_ATTENUATION;
			else if (wr_req.addr == `REG_MULTIPLEX_PARAMETERS)
				reg_mux <= wr_req.data & `MASK_MULTIPLEX_PARAMETERS;
		end
	end

	// read mux in the system domain, then carried over as a level word
	wire [15:0] stat18 = {15'h0, status_in.interp_mute_state};
	wire [15:0] stat38 = {5'h00, status_in.pll_locked, 1'b0,
		status_in.input_locked, status_in.sample_rate_code,
		status_in.pcm_detected, 1'b0, status_in.pre_emphasis, 1'b0,
		status_in.clock_accuracy};
	wire hit_sys = prep_s == `REG_SYSTEM_PARAMETERS;
	wire hit_snd = prep_s == `REG_SOUND_FEATURES;
	wire hit_vol = prep_s == `REG_VOLUME_ATTENUATION;
	wire hit_mux = prep_s == `REG_MULTIPLEX_PARAMETERS;
	wire hit_18  = prep_s == `REG_INTERPOLATOR_STATUS;
	wire hit_38  = prep_s == `REG_INPUT_LOCK_STATUS;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rd_data  <= 16'h0000;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= hit_sys | hit_snd | hit_vol | hit_mux
				| hit_18 | hit_38;
			if (hit_sys) rd_data <= reg_sys;
			else if (hit_snd) rd_data <= reg_sound;
			else if (hit_vol) rd_data <= reg_vol;
			else if (hit_mux) rd_data <= reg_mux;
			else if (hit_18) rd_data <= stat18;
			else if (hit_38) rd_data <= stat38;
			else rd_data <= 16'h0000;
		end
	end

	assign settings = '{reg_sys[13], reg_sound[13:12], reg_sound[11:8],
		reg_sound[4:3], reg_sound[2:1], reg_sound[0], reg_vol[5:0],
		reg_mux[1], reg_mux[0]};

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sys_reset_a: assert property (
		@(posedge clk_sys) disable iff (rst_n)
		##1 reg_sound == `RST_SOUND_FEATURES)
		else $error("sound features not at default");
	restore_def_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		restore |=> reg_mux == `RST_MULTIPLEX_PARAMETERS
		&& reg_sys == `RST_SYSTEM_PARAMETERS)
		else $error("restore left settings changed");
	restore_rest_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		restore |=> reg_sound == `RST_SOUND_FEATURES
		&& reg_vol == `RST_VOLUME_ATTENUATION)
		else $error("restore left sound or volume changed");
	write_apply_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		wr_event && wr_req.addr == `REG_VOLUME_ATTENUATION
		|=> settings.volume == $past(wr_req.data[5:0]))
		else $error("volume write not applied");
	sound_write_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		wr_event && wr_req.addr == `REG_SOUND_FEATURES
		|=> reg_sound == ($past(wr_req.data) & `MASK_SOUND_FEATURES))
		else $error("sound features write not applied");
	no_write_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		!wr_event |=> $stable(reg_vol))
		else $error("volume changed without write");
	mask_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(reg_mux & ~`MASK_MULTIPLEX_PARAMETERS) == 16'h0000)
		else $error("unused multiplex bits set");
	status_map_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		hit_38 |=> rd_data == $past(stat38))
		else $error("lock status word misplaced");
	prep_cross_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		prep_event |=> prep_s == $past(prep_addr))
		else $error("prepared address lost in crossing");
	invalid_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		!(hit_sys | hit_snd | hit_vol | hit_mux | hit_18 | hit_38)
		|=> !rd_valid)
		else $error("unmapped register flagged valid");
	drive_a: assert property (
		@(negedge serial_clock_line) disable iff (link_rst)
		serial_data_line_oe |-> $past(state) == S_READ)
		else $error("data line driven outside read");
	ignore_a: assert property (
		@(posedge serial_clock_line) disable iff (link_rst)
		!frame_mode_line && byte_done && !mode_edge && !addr_hit
		|=> state == S_IDLE)
		else $error("foreign address not ignored");
	read_end_a: assert property (
		@(posedge serial_clock_line) disable iff (link_rst)
		frame_mode_line && byte_done && !mode_edge
		&& state == S_READ && read_idx == 2'h2 |=> state == S_IDLE)
		else $error("read did not end after third byte");

	wr_seen_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
		wr_event);
	restore_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
		restore);
	prep_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
		prep_event);
	read_c: cover property (@(posedge serial_clock_line)
		disable iff (link_rst) state == S_READ && read_idx == 2'h2);
	invalid_c: cover property (@(posedge serial_clock_line)
		disable iff (link_rst) state == S_READ && !valid_s);
endmodule : serial_ctrl_port

//--- pkg/serial_ctrl_params.svh
`ifndef SERIAL_CTRL_PARAMS_SVH
`define SERIAL_CTRL_PARAMS_SVH
`define REG_SYSTEM_PARAMETERS    7'h00
`define REG_SOUND_FEATURES       7'h10
`define REG_VOLUME_ATTENUATION   7'h11
`define REG_INTERPOLATOR_STATUS  7'h18
`define REG_INPUT_LOCK_STATUS    7'h38
`define REG_MULTIPLEX_PARAMETERS 7'h40
`define REG_RESTORE_DEFAULTS     7'h7f
`define TYPE_WRITE_OR_PREPARE    2'h2
`define TYPE_READ_DATA           2'h3
`define DEVICE_ADDRESS_DEFAULT   6'h2a
`define RST_SYSTEM_PARAMETERS    16'h2000
`define RST_SOUND_FEATURES       16'h0001
`define RST_VOLUME_ATTENUATION   16'h0000
`define RST_MULTIPLEX_PARAMETERS 16'h0002
`define MASK_SYSTEM_PARAMETERS   16'h2000
`define MASK_SOUND_FEATURES      16'h3f1f
`define MASK_VOLUME_ATTENUATION  16'h003f
`define MASK_MULTIPLEX_PARAMETERS 16'h0003
`define BITS_PER_BYTE            3'h7
`endif

//--- pkg/serial_ctrl_pkg.sv
package serial_ctrl_pkg;
	typedef struct packed {
		logic        dac_power_on;
		logic [1:0]  filter_mode;
		logic [3:0]  bass_boost;
		logic [1:0]  treble;
		logic [1:0]  deemph_sel;
		logic        soft_mute;
		logic [5:0]  volume;
		logic        auto_mute_enable;
		logic        pll_reset;
	} settings_t;
	typedef struct packed {
		logic        interp_mute_state;
		logic        pll_locked;
		logic        input_locked;
		logic [1:0]  sample_rate_code;
		logic        pcm_detected;
		logic        pre_emphasis;
		logic [1:0]  clock_accuracy;
	} status_t;
	typedef struct packed {
		logic        wr;
		logic [6:0]  addr;
		logic [15:0] data;
	} write_req_t;
endpackage : serial_ctrl_pkg

//--- dv/serial_host.sv
`timescale 1ns/100ps
module serial_host (
	output logic      serial_clock_line,
	output logic      frame_mode_line,
	output logic      serial_data_line_in,
	input  wire logic serial_data_line_out,
	input  wire logic serial_data_line_oe
);
	// ----------------------------------------------------------------
	// wire level
	// ----------------------------------------------------------------
	logic host_d = 1'b0;
	initial serial_clock_line = 1'b1;
	initial frame_mode_line = 1'b1;
	assign serial_data_line_in = serial_data_line_oe ? serial_data_line_out
		: host_d;
	// ----------------------------------------------------------------
	// bus cycles: clock idles high and stands still between frames
	// ----------------------------------------------------------------
	task automatic pulses(input int n);
		repeat (n) begin
			serial_clock_line = 1'b0;
			#40 serial_clock_line = 1'b1;
			#40;
		end
	endtask : pulses
	task automatic put_byte(input logic m, input logic [7:0] b);
		frame_mode_line = m;
		for (int i = 0; i < 8; i++) begin
			serial_clock_line = 1'b0;
			host_d = b[i];
			#40 serial_clock_line = 1'b1;
			#40;
		end
	endtask : put_byte
	task automatic get_byte(output logic [7:0] b);
		frame_mode_line = 1'b1;
		for (int i = 0; i < 8; i++) begin
			serial_clock_line = 1'b0;
			host_d = ~host_d;
			#40 b[i] = serial_data_line_in;
			serial_clock_line = 1'b1;
			#40;
		end
	endtask : get_byte
endmodule : serial_host

//--- dv/testbench.sv
`timescale 1ns/100ps
module testbench;
	import serial_ctrl_pkg::*;
	localparam logic [5:0] DEV = 6'h15; // arbitrary
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        sclk;
	logic        mode;
	logic        din;
	logic        dout;
	logic        oe;
	status_t     status_in = '0;
	settings_t   settings;
	int          failures = 0;
	int          checked = 0;
	logic [23:0] expq[$];
	logic [23:0] obs;
	logic [15:0] r00 = 16'h2000, r10 = 16'h0001, r11 = 16'h0, r40 = 16'h2;
	event        seen;
	always #5 clk_sys = ~clk_sys;
	serial_ctrl_port #(.DEVICE_ADDRESS(DEV)) uut (.clk_sys(clk_sys),
		.rst_n(rst_n), .serial_clock_line(sclk), .frame_mode_line(mode),
		.serial_data_line_in(din), .serial_data_line_out(dout),
		.serial_data_line_oe(oe), .status_in(status_in),
		.settings(settings));
	serial_host host (.serial_clock_line(sclk), .frame_mode_line(mode),
		.serial_data_line_in(din), .serial_data_line_out(dout),
		.serial_data_line_oe(oe));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] rev8(input logic [7:0] v);
		for (int i = 0; i < 8; i++) rev8[i] = v[7 - i];
	endfunction : rev8
	always @(seen) begin
		checked++;
		if (expq.size() == 0 || obs !== expq.pop_front()) begin
			failures++;
			$display("MISMATCH at %0t: observed %h", $time, obs);
		end
	end
	task automatic check_settings();
		expq.push_back({4'h0, r00[13], r10[13:12], r10[11:8], r10[4:3],
			r10[2:1], r10[0], r11[5:0], r40[1:0]});
		repeat (6) @(negedge clk_sys);
		obs = {4'h0, settings};
		->seen;
	endtask : check_settings
	task automatic wr(input logic [5:0] dv, input logic [1:0] code,
			input logic [6:0] a, input logic [15:0] d);
		host.put_byte(1'b0, {dv, code});
		host.put_byte(1'b1, rev8({1'b0, a}));
		host.put_byte(1'b1, rev8(d[15:8]));
		host.put_byte(1'b1, rev8(d[7:0]));
		if (dv == DEV && code == 2'b10) begin
			case (a)
				7'h00: r00 = d & 16'h2000;
				7'h10: r10 = d & 16'h3f1f;
				7'h11: r11 = d & 16'h003f;
				7'h40: r40 = d & 16'h0003;
				7'h7f: {r00, r10, r11, r40} = {16'h2000, 16'h1, 16'h0, 16'h2};
				default: ;
			endcase
		end
		check_settings();
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic [15:0] d,
			input logic flag, input int n);
		logic [7:0] b;
		host.put_byte(1'b0, {DEV, 2'b10});
		host.put_byte(1'b1, rev8({1'b1, a}));
		host.put_byte(1'b0, {DEV, 2'b11});
		expq.push_back({16'h0, rev8({flag, a})});
		if (n > 1) expq.push_back({16'h0, rev8(d[15:8])});
		if (n > 2) expq.push_back({16'h0, rev8(d[7:0])});
		repeat (n) begin
			host.get_byte(b);
			obs = {16'h0, b};
			->seen;
		end
	endtask : rd
	task automatic finish_test();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [6:0] regs[4] = '{7'h00, 7'h10, 7'h11, 7'h40};
		status_t s;
		void'($urandom(32'hae74));
		// reset spans the wake-up pulses of the link
		fork
			host.pulses(4);
			repeat (5) @(negedge clk_sys);
		join
		@(negedge clk_sys) rst_n = 1'b1;
		host.pulses(3);
		check_settings();
		wr(DEV, 2'b10, 7'h40, 16'h0003);
		wr(DEV, 2'b10, 7'h7f, 16'h0000);
		foreach (regs[i]) wr(DEV, 2'b10, regs[i], 16'($urandom));
		for (int c = 0; c < 3; c++)
			wr(c == 2 ? DEV ^ 6'h01 : DEV, 2'(c), 7'h11, ~r11);
		for (int k = 0; k < 3; k++) begin
			@(negedge clk_sys) status_in = 9'($urandom);
			s = status_in;
			rd(7'h38, {5'h0, s.pll_locked, 1'b0, s.input_locked,
				s.sample_rate_code, s.pcm_detected, 1'b0, s.pre_emphasis,
				1'b0, s.clock_accuracy}, 1'b0, 3);
			rd(7'h18, {15'h0, s.interp_mute_state}, 1'b0, 3);
		end
		rd(7'h10, r10, 1'b0, 3);
		rd(7'h05, 16'h0, 1'b1, 1);
		wr(DEV, 2'b10, 7'h7f, 16'($urandom));
		finish_test();
	end
	initial begin
		#200000;
		failures++;
		finish_test();
	end
endmodule : testbench
